//--- common/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// register byte addresses
`define ACS_OFF_CTRL     12'h000
`define ACS_OFF_RES1     12'h004
`define ACS_OFF_RES2     12'h008
`define ACS_OFF_RES3     12'h00C
`define ACS_OFF_RES4     12'h010
`define ACS_OFF_IRQ_STAT 12'h014
`define ACS_OFF_IRQ_EN   12'h018
`define ACS_OFF_IRQ_CLR  12'h01C
// control register fields
`define ACS_CTRL_DONE    7
`define ACS_CTRL_ZERO    6
`define ACS_CTRL_SCAN    5
`define ACS_CTRL_GROUP   4
`define ACS_CTRL_CH_HI   3
`define ACS_CTRL_CH_LO   0
// interrupt bits
`define ACS_IRQ_DONE     0
`define ACS_IRQ_RESULT   1
`define ACS_IRQ_W        2
// channel codes
`define ACS_CH_HALF_REF  4'hE
// time that the sampling switch stays closed
`define ACS_SAMPLE_NS    96
`define ACS_CLK_NS       8
`define ACS_SAMPLE_CYC   ((`ACS_SAMPLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`endif

//--- common/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_SAMPLE,
    ACS_CONVERT
  } acs_state_t;

  typedef enum logic [2:0] {
    ACS_SRC_INPUT,
    ACS_SRC_RESERVED,
    ACS_SRC_HIGH_REF,
    ACS_SRC_LOW_REF,
    ACS_SRC_HALF_REF
  } acs_src_t;
endpackage : acs_pkg

//--- hw/acs_sequencer.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer #(
  parameter int unsigned DATA_W     = 8,
  parameter int unsigned SAMPLE_CYC = `ACS_SAMPLE_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic      [3:0]        mux_channel,
  output logic      [2:0]        mux_source,
  output logic                   sample_en,
  output logic                   half_ref_force,
  output logic                   convert_start,
  input  wire logic              convert_done,
  input  wire logic [DATA_W-1:0] convert_data
);
  acs_pkg::acs_state_t state_q, state_d;

  // setup-phase decode; the slave answers in the first access cycle
  wire setup_w  = psel & ~penable;
  wire wr_w     = setup_w & pwrite;
  wire rd_w     = setup_w & ~pwrite;
  wire hit_ctrl = (paddr == `ACS_OFF_CTRL);
  wire hit_r1   = (paddr == `ACS_OFF_RES1);
  wire hit_r2   = (paddr == `ACS_OFF_RES2);
  wire hit_r3   = (paddr == `ACS_OFF_RES3);
  wire hit_r4   = (paddr == `ACS_OFF_RES4);
  wire hit_st   = (paddr == `ACS_OFF_IRQ_STAT);
  wire hit_en   = (paddr == `ACS_OFF_IRQ_EN);
  wire hit_clr  = (paddr == `ACS_OFF_IRQ_CLR);
  wire mapped   = hit_ctrl | hit_r1 | hit_r2 | hit_r3 | hit_r4 | hit_st | hit_en | hit_clr;
  wire ctrl_wr  = wr_w & hit_ctrl;

  // control bits below bit 6 are not touched by reset
  logic [5:0] cfg_q;
  logic       cfg_init_q;
  logic       done_q;
  logic [1:0] conv_idx_q;
  logic [3:0] fresh_q;
  logic [7:0] samp_cnt_q;
  logic [DATA_W-1:0] res_q [4];
  logic [DATA_W-1:0] pend_data_q;
  logic [1:0]        pend_slot_q;
  logic              pend_q;
  logic [`ACS_IRQ_W-1:0] irq_stat_q, irq_en_q;

  // unwritten config reads as zero so the mux outputs never go unknown
  wire [5:0] cfg_w = cfg_init_q ? cfg_q : 6'h00;
  wire scan_w  = cfg_w[`ACS_CTRL_SCAN];
  wire group_w = cfg_w[`ACS_CTRL_GROUP];
  wire [3:0] sel_w = cfg_w[3:0];

  // group mode keeps the upper pair and walks the lower pair
  wire [3:0] chan_w = group_w ? {sel_w[3:2], conv_idx_q} : sel_w;
  // result slot: low bits in group mode, conversion index otherwise
  wire [1:0] slot_w = group_w ? chan_w[1:0] : conv_idx_q;

  // source decode codes 1000-1011 and 1111 stay reserved
  wire [2:0] src_w =
      (chan_w[3] == 1'b0)            ? 3'(acs_pkg::ACS_SRC_INPUT)    :
      (chan_w == 4'hC)               ? 3'(acs_pkg::ACS_SRC_HIGH_REF) :
      (chan_w == 4'hD)               ? 3'(acs_pkg::ACS_SRC_LOW_REF)  :
      (chan_w == `ACS_CH_HALF_REF)   ? 3'(acs_pkg::ACS_SRC_HALF_REF) :
                                       3'(acs_pkg::ACS_SRC_RESERVED);

  wire last_conv = (conv_idx_q == 2'h3);
  wire conv_end  = (state_q == acs_pkg::ACS_CONVERT) & convert_done & ~ctrl_wr;
  wire samp_end  = (state_q == acs_pkg::ACS_SAMPLE) & (samp_cnt_q == 8'h01);
  wire fresh_all = &(fresh_q | (4'h1 << pend_slot_q));
  // a pending result lands only in a cycle with no read setup
  wire commit_w  = pend_q & ~rd_w & ~ctrl_wr;
  wire done_set  = commit_w & fresh_all & ~done_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      acs_pkg::ACS_IDLE:    state_d = state_q;
      acs_pkg::ACS_SAMPLE:  if (samp_end) state_d = acs_pkg::ACS_CONVERT;
      acs_pkg::ACS_CONVERT: if (conv_end)
        state_d = (last_conv & ~scan_w) ? acs_pkg::ACS_IDLE : acs_pkg::ACS_SAMPLE;
    endcase
    if (ctrl_wr) state_d = acs_pkg::ACS_SAMPLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= acs_pkg::ACS_IDLE;
    else          state_q <= state_d;
  end

  // cfg_q is loaded only by software; reset leaves it alone
  always_ff @(posedge pclk) begin
    if (ctrl_wr) cfg_q <= pwdata[5:0];
  end

  // tracks whether cfg_q was ever written, so the mux outputs stay defined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)     cfg_init_q <= 1'b0;
    else if (ctrl_wr) cfg_init_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                          conv_idx_q <= 2'h0;
    else if (ctrl_wr)                      conv_idx_q <= 2'h0;
    else if (conv_end)                     conv_idx_q <= conv_idx_q + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                                    samp_cnt_q <= 8'h00;
    else if (ctrl_wr | (conv_end & ~(last_conv & ~scan_w)))
      samp_cnt_q <= 8'(SAMPLE_CYC);
    else if (samp_cnt_q != 8'h00)                    samp_cnt_q <= samp_cnt_q - 8'h01;
  end

  // the core result waits here until a read-free cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= 1'b0;
      pend_slot_q <= 2'h0;
      pend_data_q <= '0;
    end else if (ctrl_wr) begin
      pend_q      <= 1'b0;
    end else if (conv_end) begin
      pend_q      <= 1'b1;
      pend_slot_q <= slot_w;
      pend_data_q <= convert_data;
    end else if (commit_w) begin
      pend_q      <= 1'b0;
    end
  end

  // one 8-bit holding register per slot, software cannot write them
  for (genvar g = 0; g < 4; g++) begin : g_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                                  res_q[g] <= '0;
      else if (commit_w && pend_slot_q == 2'(g))     res_q[g] <= pend_data_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      fresh_q <= 4'h0;
    else if (ctrl_wr)  fresh_q <= 4'h0;
    else if (commit_w) fresh_q <= fresh_q | (4'h1 << pend_slot_q);
  end

  // in scan mode the flag stays up while results keep changing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      done_q <= 1'b0;
    else if (ctrl_wr)  done_q <= 1'b0;
    else if (done_set) done_q <= 1'b1;
  end

  // interrupt status: set wins over a same-cycle clear
  wire [`ACS_IRQ_W-1:0] ev_w = {commit_w, done_set};
  wire [`ACS_IRQ_W-1:0] clr_w = (wr_w & hit_clr) ? pwdata[`ACS_IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
      if (wr_w & hit_en) irq_en_q <= pwdata[`ACS_IRQ_W-1:0];
      irq        <= |(((irq_stat_q & ~clr_w) | ev_w) & irq_en_q);
    end
  end

  // bit 6 always reads zero
  wire [7:0] ctrl_rd = {done_q, 1'b0, cfg_init_q ? cfg_q : 6'h00};
  wire [31:0] rd_mux =
      hit_ctrl ? {24'h0, ctrl_rd} :
      hit_r1   ? {{(32-DATA_W){1'b0}}, res_q[0]} :
      hit_r2   ? {{(32-DATA_W){1'b0}}, res_q[1]} :
      hit_r3   ? {{(32-DATA_W){1'b0}}, res_q[2]} :
      hit_r4   ? {{(32-DATA_W){1'b0}}, res_q[3]} :
      hit_st   ? {{(32-`ACS_IRQ_W){1'b0}}, irq_stat_q} :
      hit_en   ? {{(32-`ACS_IRQ_W){1'b0}}, irq_en_q} :
                 32'h0000_0000;

  // read data is latched in setup, so an update after it cannot tear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~mapped;
      if (rd_w) prdata <= rd_mux;
    end
  end

  // converter-side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_channel    <= 4'h0;
      mux_source     <= 3'h0;
      sample_en      <= 1'b0;
      half_ref_force <= 1'b0;
      convert_start  <= 1'b0;
    end else begin
      mux_channel    <= chan_w;
      mux_source     <= src_w;
      sample_en      <= (state_d == acs_pkg::ACS_SAMPLE);
      half_ref_force <= (state_d == acs_pkg::ACS_SAMPLE) &&
                        (chan_w == `ACS_CH_HALF_REF);
      convert_start  <= samp_end & ~ctrl_wr;
    end
  end

  chk_done_needs_four: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done_q) |-> $past(fresh_all)) else $error("flag set without four results");
  chk_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr |=> !done_q && state_q == acs_pkg::ACS_SAMPLE && conv_idx_q == 2'h0)
    else $error("control write did not restart");
  chk_no_read_update: assert property (@(posedge pclk) disable iff (!presetn)
    rd_w |=> $stable(fresh_q)) else $error("result moved during read");
  chk_bit6_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_w && hit_ctrl |=> prdata[`ACS_CTRL_ZERO] == 1'b0) else $error("bit six not zero");
  chk_group_slot: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && group_w |=> pend_slot_q == $past(chan_w[1:0])) else $error("group slot wrong");
  chk_single_slot: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !group_w |=> pend_slot_q == $past(conv_idx_q)) else $error("single slot wrong");
  chk_group_upper: assert property (@(posedge pclk) disable iff (!presetn)
    group_w |-> chan_w[3:2] == sel_w[3:2]) else $error("group upper bits wrong");
  chk_single_chan: assert property (@(posedge pclk) disable iff (!presetn)
    !group_w |-> chan_w == sel_w) else $error("single channel wrong");
  chk_stop_after_four: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && last_conv && !scan_w |=> state_q == acs_pkg::ACS_IDLE)
    else $error("did not stop after four");
  chk_half_force: assert property (@(posedge pclk) disable iff (!presetn)
    half_ref_force |-> sample_en && mux_channel == `ACS_CH_HALF_REF)
    else $error("half reference force misplaced");
  cov_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(done_q));
  cov_scan_refresh: cover property (@(posedge pclk) disable iff (!presetn)
    done_q && commit_w && scan_w);
  cov_abort: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && state_q == acs_pkg::ACS_CONVERT);
endmodule : acs_sequencer

//--- verif/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] mux_channel,
  input  wire logic       sample_en,
  input  wire logic       half_ref_force,
  input  wire logic       convert_start,
  output logic            convert_done,
  output logic      [7:0] convert_data
);
  logic [3:0] cnt_q;
  logic       half_q;
  logic       slow_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= 4'h0;
      half_q       <= 1'b0;
      slow_q       <= 1'b0;
      convert_done <= 1'b0;
      convert_data <= 8'h00;
    end else begin
      convert_done <= 1'b0;
      // data line toggles when not valid, so a stale sample never matches
      convert_data <= ~convert_data;
      if (sample_en) begin
        // a new sample kills any conversion still pending
        cnt_q  <= 4'h0;
        half_q <= half_ref_force;
      end else if (convert_start) begin
        cnt_q  <= slow_q ? 4'h9 : 4'h3;
        slow_q <= ~slow_q;
      end else if (cnt_q == 4'h1) begin
        cnt_q        <= 4'h0;
        convert_done <= 1'b1;
        convert_data <= half_q ? 8'h80 : {mux_channel, ~mux_channel};
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : acs_core_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "acs_map.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  mux_channel;
  logic [2:0]  mux_source;
  logic        sample_en, half_ref_force, convert_start, convert_done;
  logic [7:0]  convert_data, c, code;
  logic [32:0] q[$];
  logic [31:0] rs = 32'h3702;
  int          miscompares = 0, n_tests = 0, k, i, n;

  acs_sequencer #(.SAMPLE_CYC(2)) acs_sequencer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mux_channel(mux_channel), .mux_source(mux_source), .sample_en(sample_en),
    .half_ref_force(half_ref_force), .convert_start(convert_start),
    .convert_done(convert_done), .convert_data(convert_data));
  acs_core_model acs_core_model_i (.pclk(pclk), .presetn(presetn),
    .mux_channel(mux_channel), .sample_en(sample_en), .half_ref_force(half_ref_force),
    .convert_start(convert_start), .convert_done(convert_done), .convert_data(convert_data));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic check(input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    // pready is read at the rising edge, before the slave updates it
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) miscompares++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  // watcher: every completed read is matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
      check({pslverr, prdata}, q.pop_front());

  task automatic seq(input logic [7:0] cv);
    apb(`ACS_OFF_IRQ_CLR, 1'b1, 32'h3);
    apb(`ACS_OFF_CTRL, 1'b1, {24'h0, cv | 8'h40});
    rd(`ACS_OFF_CTRL, {25'h0, cv & 8'h3F});
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    rd(`ACS_OFF_CTRL, {25'h0, (cv & 8'h3F) | 8'h80});
    for (n = 0; n < 4; n++) begin
      code = cv[4] ? {4'h0, cv[3:2], n[1:0]} : {4'h0, cv[3:0]};
      rd(12'h004 + 12'(4 * n), {25'h0, code == 8'h0E ? 8'h80 : {code[3:0], ~code[3:0]}});
    end
    $display("test ctrl %h done", cv);
  endtask : seq

  task automatic count_starts(input logic [32:0] e);
    k = 0;
    repeat (40) begin
      @(negedge pclk);
      k += int'(convert_start);
    end
    check({32'h0, k != 0}, e);
  endtask : count_starts

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ACS_OFF_CTRL, 33'h0);
    rd(`ACS_OFF_RES1, 33'h0);
    rd(12'h040, {1'b1, 32'h0});
    apb(`ACS_OFF_IRQ_EN, 1'b1, 32'h1);
    // 0..3 group mode with random low bits, then single on pins and references
    for (i = 0; i < 8; i++) begin
      rs = xs(rs);
      c = i < 4 ? {4'h1, i[1:0], rs[1:0]} : (i == 4 ? {5'h0, rs[2:0]} : {6'h3, i[1:0] - 2'b01});
      seq(c);
    end
    count_starts(33'h0);
    apb(`ACS_OFF_RES1, 1'b1, xs(rs));
    rd(`ACS_OFF_RES1, 33'h80);
    rd(`ACS_OFF_IRQ_STAT, 33'h3);
    for (i = 0; i < 3; i++) begin
      apb(i == 2 ? `ACS_OFF_IRQ_CLR : `ACS_OFF_IRQ_EN, 1'b1, i == 1 ? 32'h1 : (i == 2 ? 32'h3 : 32'h0));
      repeat (3) @(negedge pclk);
      check({32'h0, irq}, {32'h0, i == 1});
    end
    rd(`ACS_OFF_IRQ_STAT, 33'h0);
    $display("test interrupts done");
    apb(`ACS_OFF_CTRL, 1'b1, 32'h7);
    repeat (5) @(posedge pclk);
    seq(8'h02);
    seq(8'h33);
    count_starts(33'h1);
    rd(`ACS_OFF_CTRL, 33'hB3);
    $display("test scan done");
    stop_test();
  end
endmodule : tb_top
